// ---- rtl/ddic_conditioner.sv ----
// Two channel digital input conditioner with filtering, line fault checks and fault substitution.
`timescale 1ns/10ps
`default_nettype none
module ddic_conditioner
(
	input wire logic clk,
	input wire logic arst_n,
	input wire ddic_pkg::ddic_field_s fieldCh0,
	input wire ddic_pkg::ddic_field_s fieldCh1,
	input wire logic [3:0] avAddress,
	input wire logic avRead,
	input wire logic avWrite,
	input wire logic [31:0] avWritedata,
	input wire logic [3:0] avByteenable,
	output logic [31:0] avReaddata,
	output logic avWaitrequest,
	output logic [7:0] txData,
	output logic txValid,
	output logic [7:0] cfgId,
	output logic moduleError,
	output logic stationError,
	output logic chanReportValid,
	output logic [15:0] chanReport
);
	import ddic_pkg::*;

	// Slot number carried in channel reports; value is arbitrary.
	localparam logic [3:0] SLOT_ID = 4'h1;
	localparam logic DIR_INPUT = 1'b0;

	typedef struct packed {
		logic [1:0][31:0] chCfg;
		logic statusEn;
		logic [1:0] filt;
		logic [1:0][7:0] dlyCnt;
		logic [1:0] lastValid;
		logic [1:0] faultPrev;
		logic [1:0][1:0] causeSticky;
		logic [17:0] tickCnt;
		logic msTick;
		logic [20:0] sendCnt;
		logic [7:0] txData;
		logic txValid;
		logic [31:0] readdata;
		logic waitreq;
		logic modErr;
		logic stnErr;
		logic repValid;
		logic [15:0] report;
	} ddic_state_s;

	ddic_state_s st_q;
	ddic_state_s st_d;
	ddic_field_s fieldIn [2];
	logic [1:0] outBit;
	logic [1:0] outFault;
	logic [1:0] lineFault;
	logic [1:0] chanFault;
	logic [1:0] polIn;

	assign fieldIn[0] = fieldCh0;
	assign fieldIn[1] = fieldCh1;

	// Per channel polarity, line check and fault selection.
	for (genvar c = 0; c < 2; c++)
	begin : gChan
		logic [31:0] cfg;
		logic namur;
		logic simOn;
		logic baseBit;
		logic [1:0] cause;
		assign cfg = st_q.chCfg[c];
		assign namur = cfg[F_NAMUR];
		assign simOn = cfg[F_SIM];
		assign polIn[c] = fieldIn[c].level ^ cfg[F_INVERT];
		assign cause = {fieldIn[c].shortCircuit, fieldIn[c].breakage};
		assign lineFault[c] = cfg[F_LFCHK] && namur && (cause != 2'b00);
		assign chanFault[c] = (lineFault[c] && !simOn) || (simOn && !cfg[F_SIMOK]);
		assign baseBit = simOn ? cfg[F_SIMVAL] : st_q.filt[c];
		always_comb
		begin
			outBit[c] = baseBit;
			outFault[c] = chanFault[c];
			if (chanFault[c])
			begin
				unique case (ddic_fmode_e'(cfg[F_FMODE +: 2]))
					FM_CURRENT: outBit[c] = baseBit;
					FM_SUBST:
					begin
						outBit[c] = cfg[F_SUBVAL];
						outFault[c] = !cfg[F_SUBOK];
					end
					FM_LAST: outBit[c] = st_q.lastValid[c];
					default: outBit[c] = baseBit;
				endcase
			end
		end
	end

	// Next state: bus slave, tick, delay filters, framing and diagnostics.
	always_comb
	begin
		logic [7:0] dly;
		logic [31:0] merged;
		st_d = st_q;
		dly = 8'h00;
		merged = 32'h0000_0000;
		st_d.waitreq = 1'b1;
		st_d.txValid = 1'b0;
		st_d.repValid = 1'b0;
		st_d.msTick = 1'b0;
		// Avalon access completes one cycle after the request with waitrequest low.
		if ((avRead || avWrite) && st_q.waitreq)
		begin
			st_d.waitreq = 1'b0;
			st_d.readdata = UNMAPPED_READ;
			unique case (avAddress)
				ADDR_CH0_CFG, ADDR_CH1_CFG:
				begin
					merged = st_q.chCfg[avAddress[2]];
					for (int b = 0; b < 4; b++)
					begin
						if (avByteenable[b])
						begin
							merged[b*8 +: 8] = avWritedata[b*8 +: 8];
						end
					end
					if (avWrite)
					begin
						st_d.chCfg[avAddress[2]] = merged;
					end
					st_d.readdata = st_q.chCfg[avAddress[2]];
				end
				ADDR_STATUS:
				begin
					if (avWrite && avByteenable[0])
					begin
						st_d.statusEn = avWritedata[0];
					end
					st_d.readdata = {23'h000000, st_q.causeSticky[1], st_q.causeSticky[0],
						st_q.filt, chanFault, st_q.statusEn};
					// Reading clears sticky causes; a cause present this cycle stays set.
					if (avRead)
					begin
						st_d.causeSticky[0] = 2'b00;
						st_d.causeSticky[1] = 2'b00;
					end
				end
				ADDR_CFGID: st_d.readdata = {24'h000000, CFG_ID};
				default: st_d.readdata = UNMAPPED_READ;
			endcase
		end
		else if (!(avRead || avWrite))
		begin
			st_d.waitreq = 1'b1;
		end
		// Millisecond tick from the system clock.
		if (st_q.tickCnt == 18'(TICK_CYCLES - 1))
		begin
			st_d.tickCnt = 18'h00000;
			st_d.msTick = 1'b1;
		end
		else
		begin
			st_d.tickCnt = st_q.tickCnt + 18'h00001;
		end
		// ON and OFF delay filters; zero delay follows at once.
		for (int c = 0; c < 2; c++)
		begin
			dly = polIn[c] ? st_q.chCfg[c][F_ONDLY +: 8] : st_q.chCfg[c][F_OFFDLY +: 8];
			if (polIn[c] == st_q.filt[c])
			begin
				st_d.dlyCnt[c] = 8'h00;
			end
			else if (dly == 8'h00)
			begin
				st_d.filt[c] = polIn[c];
			end
			else if (st_q.msTick)
			begin
				if (st_q.dlyCnt[c] + 8'h01 >= dly)
				begin
					st_d.filt[c] = polIn[c];
					st_d.dlyCnt[c] = 8'h00;
				end
				else
				begin
					st_d.dlyCnt[c] = st_q.dlyCnt[c] + 8'h01;
				end
			end
			// Capture last valid value while the channel is healthy.
			if (!chanFault[c])
			begin
				st_d.lastValid[c] = outBit[c];
			end
			// Channel report on fault onset, sticky causes set over any clear.
			st_d.faultPrev[c] = chanFault[c];
			if (lineFault[c])
			begin
				st_d.causeSticky[c] = st_d.causeSticky[c] |
					{fieldIn[c].shortCircuit, fieldIn[c].breakage};
			end
		end
		for (int c = 0; c < 2; c++)
		begin
			if (chanFault[c] && !st_q.faultPrev[c] && !st_d.repValid)
			begin
				st_d.repValid = 1'b1;
				st_d.report = {SLOT_ID, 3'(c), DIR_INPUT, 6'h00,
					fieldIn[c].shortCircuit, fieldIn[c].breakage};
				st_d.faultPrev[c] = 1'b1;
			end
			else if (chanFault[c] && !st_q.faultPrev[c])
			begin
				st_d.faultPrev[c] = 1'b0;
			end
		end
		st_d.modErr = st_q.statusEn && (chanFault != 2'b00);
		st_d.stnErr = st_q.statusEn && (chanFault != 2'b00);
		// Periodic frame to the communication unit.
		if (st_q.sendCnt == 21'(SEND_CYCLES - 1))
		begin
			st_d.sendCnt = 21'h000000;
			st_d.txValid = 1'b1;
			st_d.txData = {4'h0, outFault[1], outBit[1], outFault[0], outBit[0]};
		end
		else
		begin
			st_d.sendCnt = st_q.sendCnt + 21'h000001;
		end
	end

	// State register.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			st_q <= '0;
			st_q.chCfg <= {CH_CFG_RESET, CH_CFG_RESET};
			st_q.waitreq <= 1'b1;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	assign avReaddata = st_q.readdata;
	assign avWaitrequest = st_q.waitreq;
	assign txData = st_q.txData;
	assign txValid = st_q.txValid;
	assign cfgId = CFG_ID;
	assign moduleError = st_q.modErr;
	assign stationError = st_q.stnErr;
	assign chanReportValid = st_q.repValid;
	assign chanReport = st_q.report;

	// Each frame strobe is followed by at least eight cycles without a strobe.
	sequence sFrame;
		txValid ##1 !txValid [*8];
	endsequence
	chk_frame_spacing: assert property (@(posedge clk) disable iff (!arst_n) txValid |-> sFrame)
		else $error("Frame strobe repeated too soon.");
	chk_unused_bits: assert property (@(posedge clk) disable iff (!arst_n) txValid |-> txData[7:4] == 4'h0)
		else $error("Unused frame bits set.");
	chk_zero_delay: assert property (@(posedge clk) disable iff (!arst_n)
		(st_q.chCfg[0][F_ONDLY +: 8] == 8'h00 && st_q.chCfg[0][F_OFFDLY +: 8] == 8'h00 && $stable(st_q.chCfg[0])
		&& st_q.filt[0] != polIn[0]) |=> st_q.filt[0] == $past(polIn[0]))
		else $error("Zero delay did not pass edge.");
	chk_sim_value: assert property (@(posedge clk) disable iff (!arst_n)
		(st_q.chCfg[0][F_SIM] && st_q.chCfg[0][F_SIMOK]) |-> outBit[0] == st_q.chCfg[0][F_SIMVAL])
		else $error("Simulation value not sent.");
	chk_sim_invalid: assert property (@(posedge clk) disable iff (!arst_n)
		(st_q.chCfg[1][F_SIM] && !st_q.chCfg[1][F_SIMOK]) |-> chanFault[1])
		else $error("Invalid simulation not treated as fault.");
	chk_namur_only: assert property (@(posedge clk) disable iff (!arst_n)
		!st_q.chCfg[0][F_NAMUR] |-> !lineFault[0])
		else $error("Line fault on non NAMUR channel.");
	chk_subst_value: assert property (@(posedge clk) disable iff (!arst_n)
		(chanFault[0] && st_q.chCfg[0][F_FMODE +: 2] == 2'b01) |-> outBit[0] == st_q.chCfg[0][F_SUBVAL])
		else $error("Substitute value not sent.");
	chk_last_hold: assert property (@(posedge clk) disable iff (!arst_n)
		(chanFault[1] && $past(chanFault[1]) && st_q.chCfg[1][F_FMODE +: 2] == 2'b10) |-> $stable(st_q.lastValid[1]))
		else $error("Last valid value changed during fault.");
	chk_status_err: assert property (@(posedge clk) disable iff (!arst_n)
		(st_q.statusEn && chanFault != 2'b00 && $stable(chanFault)) |=> (moduleError && stationError))
		else $error("Module error not flagged.");
	chk_bus_answer: assert property (@(posedge clk) disable iff (!arst_n)
		(avRead || avWrite) && avWaitrequest |-> ##[0:1] !avWaitrequest)
		else $error("Bus access not answered.");
endmodule : ddic_conditioner
`default_nettype wire

// ---- rtl/ddic_pkg.sv ----
// Package with constants, register map and types of the dual digital input conditioner.
package ddic_pkg;
	// Timing: 250 MHz clock, one millisecond tick, 6.5 ms transmit period.
	localparam int CLK_HZ = 250000000;
	localparam int TICK_MS = 1;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int SEND_PERIOD_US = 6500;
	localparam int SEND_CYCLES = CLK_HZ / 1000000 * SEND_PERIOD_US;
	localparam int MAX_INPUT_HZ = 50;
	localparam int MIN_HALF_PERIOD_MS = 1000 / (2 * MAX_INPUT_HZ);
	// Cyclic data configuration identifier.
	localparam logic [7:0] CFG_ID = 8'h0A;
	// Register byte addresses.
	localparam logic [3:0] ADDR_CH0_CFG = 4'h0;
	localparam logic [3:0] ADDR_CH1_CFG = 4'h4;
	localparam logic [3:0] ADDR_STATUS = 4'h8;
	localparam logic [3:0] ADDR_CFGID = 4'hC;
	// Channel configuration field positions.
	localparam int F_INVERT = 0;
	localparam int F_SIM = 1;
	localparam int F_SIMVAL = 2;
	localparam int F_SIMOK = 3;
	localparam int F_FMODE = 4;
	localparam int F_SUBVAL = 6;
	localparam int F_SUBOK = 7;
	localparam int F_LFCHK = 8;
	localparam int F_NAMUR = 9;
	localparam int F_ONDLY = 16;
	localparam int F_OFFDLY = 24;
	localparam logic [31:0] CH_CFG_RESET = 32'h0000_0000;
	localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
	// Fault response modes.
	typedef enum logic [1:0] {
		FM_CURRENT = 2'b00,
		FM_SUBST = 2'b01,
		FM_LAST = 2'b10
	} ddic_fmode_e;
	// Per channel field condition from the sensing front end.
	typedef struct packed {
		logic level;
		logic breakage;
		logic shortCircuit;
	} ddic_field_s;
	// Avalon-MM slave request.
	typedef struct packed {
		logic [3:0] address;
		logic read;
		logic write;
		logic [31:0] writedata;
	} ddic_avreq_s;
	// Transmitted frame towards the communication unit.
	typedef struct packed {
		logic [7:0] data;
		logic valid;
	} ddic_frame_s;
endpackage : ddic_pkg

// ---- verification/ddic_comm_model.sv ----
// Model of the communication unit that collects the packed input byte.
`timescale 1ns/10ps
`default_nettype none
module ddic_comm_model
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [7:0] txData,
	input wire logic txValid,
	input wire logic [7:0] cfgId,
	output var int frameCount,
	output logic [7:0] lastByte
);
	import ddic_pkg::*;
	// Frames are taken only while the slave shows the expected identifier.
	always @(negedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			frameCount <= 0;
			lastByte <= 8'h00;
		end
		else if (txValid === 1'b1 && cfgId === CFG_ID)
		begin
			frameCount <= frameCount + 1;
			lastByte <= txData;
		end
	end
endmodule : ddic_comm_model
`default_nettype wire

// ---- verification/dual_digital_input_conditioner_tb.sv ----
// Self-checking testbench of the dual digital input conditioner.
`timescale 1ns/10ps
`default_nettype none
module dual_digital_input_conditioner_tb;
	import ddic_pkg::*;
	logic clk;
	logic arst_n;
	ddic_field_s fieldCh0;
	ddic_field_s fieldCh1;
	logic [3:0] avAddress;
	logic avRead;
	logic avWrite;
	logic [31:0] avWritedata;
	logic [31:0] avReaddata;
	logic avWaitrequest;
	logic [7:0] txData;
	logic txValid;
	logic [7:0] cfgId;
	logic moduleError;
	logic stationError;
	logic chanReportValid;
	logic [15:0] chanReport;
	int frameCount;
	int fail_count;
	int comparisons;
	logic [15:0] lastRep;
	logic [31:0] q;
	ddic_conditioner uut
	(
		.clk(clk), .arst_n(arst_n), .fieldCh0(fieldCh0), .fieldCh1(fieldCh1),
		.avAddress(avAddress), .avRead(avRead), .avWrite(avWrite), .avWritedata(avWritedata),
		.avByteenable(4'hF), .avReaddata(avReaddata), .avWaitrequest(avWaitrequest),
		.txData(txData), .txValid(txValid), .cfgId(cfgId), .moduleError(moduleError),
		.stationError(stationError), .chanReportValid(chanReportValid), .chanReport(chanReport)
	);
	ddic_comm_model partner
	(
		.clk(clk), .arst_n(arst_n), .txData(txData), .txValid(txValid), .cfgId(cfgId),
		.frameCount(frameCount), .lastByte()
	);
	// Free running clock.
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Keeps the last channel report, sampled away from the launching edge.
	always @(negedge clk)
	begin
		if (chanReportValid === 1'b1)
			lastRep <= chanReport;
	end
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
	begin
		comparisons++;
		if (got !== exp)
		begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	end
	endtask : check
	// One bus cycle; the request stands until waitrequest is seen low.
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
	begin
		n = 0;
		@(posedge clk);
		avAddress <= a;
		avWrite <= wr;
		avRead <= ~wr;
		avWritedata <= d;
		// Waitrequest is sampled at each rising edge; the answer edge is the second one.
		do
		begin
			@(posedge clk);
			n++;
		end
		while (avWaitrequest !== 1'b0);
		check("bus answer", 32'h2, 32'(n));
		q = avReaddata;
		avRead <= 1'b0;
		avWrite <= 1'b0;
	end
	endtask : bus
	task automatic wrReg(input logic [3:0] a, input logic [31:0] d);
	begin
		bus(1'b1, a, d);
		repeat (3) @(posedge clk);
	end
	endtask : wrReg
	task automatic setField(input logic [2:0] f0, input logic [2:0] f1);
	begin
		@(posedge clk);
		fieldCh0 <= f0;
		fieldCh1 <= f1;
		repeat (3) @(posedge clk);
	end
	endtask : setField
	task automatic test_regs;
	begin
		check("id port", 32'hA, {24'h0, cfgId});
		bus(1'b0, ADDR_CFGID, 32'h0);
		check("id reg", 32'hA, q);
		bus(1'b0, ADDR_CH1_CFG, 32'h0);
		check("cfg reset", CH_CFG_RESET, q);
		wrReg(4'h2, 32'hFFFF_FFFF);
		bus(1'b0, 4'h2, 32'h0);
		check("unmapped", UNMAPPED_READ, q);
	end
	endtask : test_regs
	task automatic test_polarity;
	begin
		setField(3'b100, 3'b000);
		bus(1'b0, ADDR_STATUS, 32'h0);
		check("states", 32'h1, {30'h0, q[4:3]});
		wrReg(ADDR_CH0_CFG, 32'h1);
		wrReg(ADDR_CH1_CFG, 32'h1);
		bus(1'b0, ADDR_STATUS, 32'h0);
		check("inverted", 32'h2, {30'h0, q[4:3]});
		wrReg(ADDR_CH0_CFG, 32'h0);
		wrReg(ADDR_CH1_CFG, 32'h0);
	end
	endtask : test_polarity
	task automatic test_line_fault;
	begin
		wrReg(ADDR_STATUS, 32'h1);
		wrReg(ADDR_CH0_CFG, 32'h300);
		setField(3'b010, 3'b000);
		bus(1'b0, ADDR_STATUS, 32'h0);
		check("ch0 fault", 32'h1, {31'h0, q[1]});
		check("ch0 break", 32'h1, {31'h0, q[5]});
		check("errors", 32'h3, {30'h0, moduleError, stationError});
		check("ch0 report", 32'h1001, {16'h0, lastRep});
		wrReg(ADDR_CH0_CFG, 32'h100);
		bus(1'b0, ADDR_STATUS, 32'h0);
		check("contact", 32'h0, {31'h0, q[1]});
		wrReg(ADDR_CH1_CFG, 32'h300);
		setField(3'b000, 3'b001);
		bus(1'b0, ADDR_STATUS, 32'h0);
		check("ch1 fault", 32'h1, {31'h0, q[2]});
		check("ch1 short", 32'h2, {30'h0, q[8:7]});
		check("ch1 report", 32'h1202, {16'h0, lastRep});
		wrReg(ADDR_CH1_CFG, 32'h200);
		bus(1'b0, ADDR_STATUS, 32'h0);
		check("check off", 32'h0, {31'h0, q[2]});
		check("no error", 32'h0, {31'h0, moduleError});
		setField(3'b000, 3'b000);
	end
	endtask : test_line_fault
	// Substitute and last valid modes on a broken first channel still flag the fault.
	task automatic test_fault_modes;
	begin
		wrReg(ADDR_CH0_CFG, 32'h350);
		setField(3'b010, 3'b000);
		bus(1'b0, ADDR_STATUS, 32'h0);
		check("subst fault", 32'h1, {31'h0, q[1]});
		wrReg(ADDR_CH0_CFG, 32'h320);
		bus(1'b0, ADDR_STATUS, 32'h0);
		check("last fault", 32'h1, {31'h0, q[1]});
		wrReg(ADDR_CH0_CFG, 32'h0);
		setField(3'b000, 3'b000);
	end
	endtask : test_fault_modes
	task automatic test_simulation;
	begin
		wrReg(ADDR_CH0_CFG, 32'h2);
		bus(1'b0, ADDR_STATUS, 32'h0);
		check("sim invalid", 32'h1, {31'h0, q[1]});
		wrReg(ADDR_CH0_CFG, 32'hE);
		bus(1'b0, ADDR_STATUS, 32'h0);
		check("sim valid", 32'h0, {31'h0, q[1]});
		wrReg(ADDR_CH0_CFG, 32'h0);
		check("early frame", 32'h0, 32'(frameCount));
	end
	endtask : test_simulation
	task automatic test_done;
	begin
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	end
	endtask : test_done
	// Main sequence: reset for 12 cycles, then the scenarios.
	initial
	begin
		arst_n = 1'b0;
		fieldCh0 = 3'b000;
		fieldCh1 = 3'b000;
		avAddress = 4'h0;
		avRead = 1'b0;
		avWrite = 1'b0;
		avWritedata = 32'h0;
		lastRep = 16'h0;
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		check("idle wait", 32'h1, {31'h0, avWaitrequest});
		test_regs();
		test_polarity();
		test_line_fault();
		test_fault_modes();
		test_simulation();
		test_done();
	end
	// Watchdog well beyond the roughly 170 cycles the scenarios need.
	initial
	begin
		repeat (20000) @(posedge clk);
		fail_count++;
		test_done();
	end
endmodule : dual_digital_input_conditioner_tb
`default_nettype wire
